// File: dmx_data_mem.sv
/*
 Data-memory decoder: internal RAM, special registers, expanded RAM, dual pointer, bus start.
 Assumes the core holds a request until ready and drives ALU flag updates on the same clock.
*/
`timescale 1ns/1ps
module dmx_data_mem import dmx_pkg::*; (
	input wire logic clock,
	input wire logic rst,
	input dmx_req_type req,
	output logic req_ready,
	output dmx_rsp_type rsp,
	input dmx_alu_type alu,
	input wire logic [7:0] acc,
	input wire logic code_read_strobe,
	input wire logic [7:0] p0_in,
	output dmx_bus_type bus
);
	logic [7:0] iram [256];
	logic [7:0] expanded_ram [EXPANDED_RAM_DEPTH];
	logic [7:1] psw_r;
	logic [5:0] aux_r;
	logic [7:0] aux1_r;
	logic [7:0] p2_r;
	logic [15:0] data_pointer_reg_r [2];
	dmx_tgt_type tgt;
	logic [7:0] iaddr;
	logic [2:0] bitsel;
	logic isbit;
	logic [15:0] xaddr;
	logic [7:0] psw_rd, sfr_rd, wval;
	logic fire, wr_any, wr_sfr, psel;
	logic xstart, xbusy, xdone;
	logic xwr_r;
	logic [7:0] xrdata;

	assign psel = aux1_r[AUX1_PSEL];
	assign psw_rd = {psw_r, ^acc};
	assign req_ready = !xbusy;
	assign fire = req.valid && req_ready;
	assign wr_any = req.op != OP_READ;
	assign wr_sfr = fire && tgt == T_SFR && wr_any;
	assign xstart = fire && tgt == T_XBUS;

	// external move lands in expanded RAM only below the configured size
	function automatic logic in_expanded_ram(input logic [15:0] a);
		return !aux_r[AUX_EXT] &&
			a < {4'h0, expanded_ram_size_bytes(aux_r[AUX_SZ_HI:AUX_SZ_LO])};
	endfunction

	always_comb begin
		tgt = T_NONE;
		iaddr = 8'h00;
		bitsel = 3'h0;
		isbit = 1'b0;
		xaddr = 16'h0000;
		unique case (req.kind)
			K_DIRECT: begin
				tgt = req.addr[7] ? T_SFR : T_IRAM;
				iaddr = req.addr[7:0];
			end
			K_INDIRECT: begin
				tgt = T_IRAM;
				iaddr = req.addr[7:0];
			end
			K_BANKREG: begin
				tgt = T_IRAM;
				iaddr = {3'h0, psw_r[PSW_RS_HI:PSW_RS_LO], req.addr[2:0]};
			end
			K_BIT: begin
				isbit = 1'b1;
				bitsel = req.addr[2:0];
				if (req.addr[7]) begin
					tgt = T_SFR;
					iaddr = {req.addr[7:3], 3'h0};
				end else begin
					tgt = T_IRAM;
					iaddr = BIT_BASE + {4'h0, req.addr[6:3]};
				end
			end
			K_MOVX_RI: begin
				xaddr = {p2_r, req.addr[7:0]};
				tgt = in_expanded_ram(xaddr) ? T_EXPANDED_RAM : T_XBUS;
			end
			K_MOVX_DP: begin
				xaddr = data_pointer_reg_r[psel];
				tgt = in_expanded_ram(xaddr) ? T_EXPANDED_RAM : T_XBUS;
			end
			K_DATA_POINTER_REG: tgt = T_DATA_POINTER_REG;
			default: tgt = T_NONE;
		endcase
	end

	always_comb begin
		unique case (iaddr)
			SFR_PSW: sfr_rd = psw_rd;
			SFR_AUX: sfr_rd = {2'h0, aux_r};
			SFR_AUX1: sfr_rd = aux1_r;
			SFR_DPH: sfr_rd = data_pointer_reg_r[psel][15:8];
			SFR_DPL: sfr_rd = data_pointer_reg_r[psel][7:0];
			SFR_P2: sfr_rd = p2_r;
			default: sfr_rd = 8'h00;
		endcase
		wval = isbit ? set_bit(sfr_rd, bitsel, req.wdata[0]) : req.wdata;
	end

	// contents keep no reset value
	always_ff @(posedge clock) begin
		if (fire && tgt == T_IRAM && wr_any) begin
			if (isbit)
				iram[iaddr] <= set_bit(iram[iaddr], bitsel, req.wdata[0]);
			else
				iram[iaddr] <= req.wdata;
		end
	end

	always_ff @(posedge clock) begin
		if (fire && tgt == T_EXPANDED_RAM && wr_any)
			expanded_ram[xaddr[10:0]] <= req.wdata;
	end

	// alu update placed last so a same-cycle flag set beats a software write
	always_ff @(posedge clock) begin
		if (rst) begin
			psw_r <= PSW_RST[7:1];
		end else begin
			if (wr_sfr && iaddr == SFR_PSW)
				psw_r <= wval[7:1];
			if (alu.valid) begin
				psw_r[PSW_CY] <= alu.carry;
				psw_r[PSW_AC] <= alu.half;
				psw_r[PSW_OV] <= alu.ovf;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst)
			aux_r <= AUX_RST;
		else if (wr_sfr && iaddr == SFR_AUX)
			aux_r <= wval[5:0];
	end

	always_ff @(posedge clock) begin
		if (rst)
			aux1_r <= AUX1_RST;
		else if (wr_sfr && iaddr == SFR_AUX1) begin
			if (req.op == OP_INC && !isbit)
				aux1_r[AUX1_PSEL] <= !aux1_r[AUX1_PSEL];
			else
				aux1_r <= wval & AUX1_MASK;
		end
	end

	always_ff @(posedge clock) begin
		if (rst)
			p2_r <= P2_RST;
		else if (wr_sfr && iaddr == SFR_P2)
			p2_r <= wval;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			data_pointer_reg_r[0] <= 16'h0000;
			data_pointer_reg_r[1] <= 16'h0000;
		end else if (wr_sfr && iaddr == SFR_DPH) begin
			data_pointer_reg_r[psel][15:8] <= wval;
		end else if (wr_sfr && iaddr == SFR_DPL) begin
			data_pointer_reg_r[psel][7:0] <= wval;
		end else if (fire && tgt == T_DATA_POINTER_REG) begin
			if (req.op == OP_INC)
				data_pointer_reg_r[psel] <= data_pointer_reg_r[psel] + 16'h0001;
			else if (req.op == OP_WRITE)
				data_pointer_reg_r[psel] <= req.addr;
		end
	end

	always_ff @(posedge clock) begin
		if (rst)
			xwr_r <= 1'b0;
		else if (xstart)
			xwr_r <= wr_any;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			rsp <= '{valid: 1'b0, rdata: 8'h00};
		end else begin
			rsp.valid <= (fire && tgt != T_XBUS) || xdone;
			if (xdone)
				rsp.rdata <= xwr_r ? 8'h00 : xrdata;
			else if (fire) begin
				unique case (tgt)
					T_IRAM: rsp.rdata <= isbit ? {7'h00, iram[iaddr][bitsel]} : iram[iaddr];
					T_SFR: rsp.rdata <= isbit ? {7'h00, sfr_rd[bitsel]} : sfr_rd;
					T_EXPANDED_RAM: rsp.rdata <= expanded_ram[xaddr[10:0]];
					default: rsp.rdata <= 8'h00;
				endcase
			end
		end
	end

	dmx_xbus_seq u_seq (
		.clock(clock),
		.rst(rst),
		.start(xstart),
		.wr(wr_any),
		.addr(xaddr),
		.wdata(req.wdata),
		.stretch(aux_r[AUX_STRETCH]),
		.suppress(aux_r[AUX_SUPP]),
		.code_read_strobe(code_read_strobe),
		.p0_in(p0_in),
		.busy(xbusy),
		.done(xdone),
		.rdata(xrdata),
		.bus(bus)
	);

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	lower_map_a: assert property (
		fire && req.kind == K_DIRECT && !req.addr[7] |-> tgt == T_IRAM && iaddr == req.addr[7:0])
		else $error("direct low address not mapped to lower ram");
	bank_map_a: assert property (
		fire && req.kind == K_BANKREG |->
		iaddr == {3'h0, psw_r[PSW_RS_HI:PSW_RS_LO], req.addr[2:0]} && iaddr < 8'h20)
		else $error("bank register maps outside active bank");
	bit_map_a: assert property (
		fire && req.kind == K_BIT && !req.addr[7] |->
		iaddr == 8'h20 + {4'h0, req.addr[6:3]} && bitsel == req.addr[2:0])
		else $error("bit address decoded wrong");
	upper_ind_a: assert property (
		fire && req.kind == K_INDIRECT && req.addr[7] |-> tgt == T_IRAM && iaddr[7])
		else $error("indirect upper access not in upper ram");
	sfr_route_a: assert property (
		fire && req.kind == K_DIRECT && req.addr[7] |-> tgt == T_SFR)
		else $error("direct upper access not routed to special registers");
	expanded_ram_sel_a: assert property (
		fire && req.kind == K_MOVX_DP && aux_r[AUX_EXT] |-> tgt == T_XBUS)
		else $error("external select did not force bus cycle");
	size_lim_a: assert property (
		fire && (req.kind == K_MOVX_DP || req.kind == K_MOVX_RI) &&
		xaddr >= {4'h0, expanded_ram_size_bytes(aux_r[AUX_SZ_HI:AUX_SZ_LO])} |-> tgt == T_XBUS)
		else $error("access above expanded size kept internal");
	xcycle_std_a: assert property (
		xstart && !aux_r[AUX_STRETCH] |-> !xdone[*6] ##1 xdone)
		else $error("external cycle not six clocks");
	strobe_long_a: assert property (
		$fell(bus.rd_n) && $past(aux_r[AUX_STRETCH], 4) && $past(aux_r[AUX_STRETCH], 3)
		|-> !bus.rd_n[*8] ##1 !bus.rd_n[*7] ##1 bus.rd_n)
		else $error("stretched read strobe not fifteen clocks");
	strobe_std_a: assert property (
		$fell(bus.wr_n) && !$past(aux_r[AUX_STRETCH], 3) |-> !bus.wr_n[*3] ##1 bus.wr_n)
		else $error("write strobe not three clocks");
	ptr_toggle_a: assert property (
		wr_sfr && iaddr == SFR_AUX1 && req.op == OP_INC && !isbit
		|=> psel != $past(psel) && $stable(aux1_r[7:1]))
		else $error("increment did not toggle pointer select");
	ale_quiet_a: assert property (
		bus.ale && !xbusy && $past(aux_r[AUX_SUPP]) |-> $past(code_read_strobe))
		else $error("latch strobe pulsed while suppressed");
	ri_high_a: assert property (
		xstart && req.kind == K_MOVX_RI |=> bus.p2_out == $past(p2_r))
		else $error("port two did not keep its latch");
	psw_rst_a: assert property (@(posedge clock) disable iff (1'b0)
		rst |=> psw_r == 7'h00)
		else $error("status word not cleared by reset");
	aux_rst_a: assert property (@(posedge clock) disable iff (1'b0)
		rst |=> aux_r == 6'h14 && !psel)
		else $error("aux control reset value wrong");
	bank_one_a: assert property (
		fire && req.kind == K_BANKREG |-> tgt == T_IRAM && iaddr[7:5] == 3'h0)
		else $error("bank register outside the lowest 32 bytes");
	iram_write_a: assert property (
		fire && tgt == T_IRAM && wr_any && !isbit
		|=> iram[$past(iaddr)] == $past(req.wdata))
		else $error("internal ram write lost");
	expanded_ram_hit_a: assert property (
		fire && req.kind == K_MOVX_DP && !aux_r[AUX_EXT] && xaddr < 16'h0100
		|-> tgt == T_EXPANDED_RAM)
		else $error("low external move missed expanded ram");
	expanded_ram_fast_a: assert property (
		fire && tgt == T_EXPANDED_RAM |=> rsp.valid && req_ready)
		else $error("expanded ram access started a bus cycle");
	size_code_a: assert property (
		fire && req.kind == K_MOVX_DP && !aux_r[AUX_EXT] &&
		aux_r[AUX_SZ_HI:AUX_SZ_LO] == 3'h4 && xaddr == 16'h06FF |-> tgt == T_EXPANDED_RAM)
		else $error("size code 100 does not reach 1792 bytes");
	above_top_a: assert property (
		fire && (req.kind == K_MOVX_DP || req.kind == K_MOVX_RI) && xaddr > 16'h07FF
		|-> tgt == T_XBUS)
		else $error("access above the expanded range kept internal");
	addr_out_a: assert property (
		xstart |=> bus.ale && bus.p0_oe && bus.p0_out == $past(xaddr[7:0]) &&
		bus.p2_out == $past(xaddr[15:8]))
		else $error("address phase wrong on ports");
	data_out_a: assert property (
		xstart && wr_any |-> ##3 !bus.wr_n && bus.p0_oe &&
		bus.p0_out == $past(req.wdata, 3))
		else $error("write data not on port zero");
	read_release_a: assert property (
		xstart && !wr_any |-> ##3 !bus.rd_n && !bus.p0_oe)
		else $error("read strobe without released port zero");
	hold_quiet_a: assert property (
		xdone |-> bus.rd_n && bus.wr_n && !bus.ale)
		else $error("strobe active in hold phase");
	ale_strobe_a: assert property (
		!bus.rd_n || !bus.wr_n |-> !bus.ale)
		else $error("latch strobe during data strobe");
	ready_low_a: assert property (
		xstart && !aux_r[AUX_STRETCH] |=> !req_ready[*6] ##1 req_ready)
		else $error("bus busy time not six clocks");
	xcycle_long_a: assert property (
		xstart && aux_r[AUX_STRETCH] |-> !xdone[*8] ##1 !xdone[*8] ##1 !xdone[*2] ##1 xdone)
		else $error("stretched cycle length wrong");
	wr_long_a: assert property (
		$fell(bus.wr_n) && $past(aux_r[AUX_STRETCH], 4) && $past(aux_r[AUX_STRETCH], 3)
		|-> !bus.wr_n[*8] ##1 !bus.wr_n[*7] ##1 bus.wr_n)
		else $error("stretched write strobe not fifteen clocks");
	data_pointer_reg_load_a: assert property (
		fire && req.kind == K_DATA_POINTER_REG && req.op == OP_WRITE
		|=> data_pointer_reg_r[$past(psel)] == $past(req.addr))
		else $error("selected pointer not loaded");
	alu_flags_a: assert property (
		alu.valid |=> psw_r[PSW_OV] == $past(alu.ovf) &&
		psw_r[PSW_CY] == $past(alu.carry))
		else $error("status flags not taken from the alu");
	psw_write_a: assert property (
		wr_sfr && iaddr == SFR_PSW && !isbit && !alu.valid
		|=> psw_r == $past(req.wdata[7:1]))
		else $error("status word write lost");
	bus_rst_a: assert property (@(posedge clock) disable iff (1'b0)
		rst |=> bus.rd_n && bus.wr_n && !bus.ale && !bus.p0_oe)
		else $error("bus strobes active after reset");

	xread_c: cover property (xstart && !wr_any ##7 rsp.valid);
	xwrite_c: cover property (xstart && wr_any && aux_r[AUX_STRETCH]);
	slow_read_c: cover property (xstart && !wr_any && aux_r[AUX_STRETCH]);
	expanded_ram_c: cover property (fire && tgt == T_EXPANDED_RAM && wr_any ##2 fire && tgt == T_EXPANDED_RAM);
	toggle_c: cover property (wr_sfr && iaddr == SFR_AUX1 && req.op == OP_INC);
endmodule // dmx_data_mem

// File: dmx_data_mem_bench.sv
/*
 Self-checking bench for the data-memory decoder and its external bus cycles.
 Assumes dmx_pkg and the external memory model are compiled first.
*/
`timescale 1ns/1ps
module dmx_data_mem_bench import dmx_pkg::*; ;
	localparam logic [15:0] SZ_TAB [6] = '{16'h0100, 16'h0200, 16'h0300, 16'h0400, 16'h0700, 16'h0800};
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic code_read_strobe = 1'b0;
	logic slow = 1'b0;
	logic [7:0] acc = 8'h00;
	dmx_req_type req = '0;
	dmx_alu_type alu = '0;
	logic req_ready;
	dmx_rsp_type rsp;
	logic [7:0] p0_in;
	dmx_bus_type bus;
	int err_count = 0;
	int samples_checked = 0;
	int cyc = 0;
	int rd_lo = 0;
	int wr_lo = 0;
	int ale_hi = 0;
	int oe_hi = 0;
	logic [7:0] rnd = 8'h4E;
	logic [7:0] q;
	logic [7:0] p2_seen;
	logic [15:0] lat;
	logic [15:0] a;

	always #5 clock = ~clock;

	dmx_data_mem i_dmx_data_mem (.clock(clock), .rst(rst), .req(req), .req_ready(req_ready),
		.rsp(rsp), .alu(alu), .acc(acc), .code_read_strobe(code_read_strobe), .p0_in(p0_in),
		.bus(bus));
	dmx_xmem_model i_dmx_xmem_model (.clock(clock), .slow(slow), .bus(bus), .p0_in(p0_in));

	// bus activity seen mid-cycle
	always @(negedge clock) begin
		if (!bus.rd_n) rd_lo++;
		if (!bus.wr_n) wr_lo++;
		if (bus.p0_oe) oe_hi++;
		if (bus.ale) begin
			ale_hi++;
			p2_seen = bus.p2_out;
		end
	end

	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			err_count++;
			stop_test();
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// hold the request until taken, then count cycles to the answer
	task automatic xfer(input dmx_kind_type k, input dmx_op_type o, input logic [15:0] ad,
		input logic [7:0] d);
		req <= '{1'b1, k, o, ad, d};
		@(negedge clock);
		while (req_ready !== 1'b1) begin
			@(posedge clock);
			@(negedge clock);
		end
		@(posedge clock);
		req <= '0;
		lat = 16'h0000;
		do begin
			@(negedge clock);
			lat++;
		end while (rsp.valid !== 1'b1 && lat < 16'h0028);
		q = rsp.rdata;
		@(posedge clock);
	endtask

	task automatic wrt(input dmx_kind_type k, input logic [15:0] ad, input logic [7:0] d);
		xfer(k, OP_WRITE, ad, d);
	endtask

	task automatic rdc(input dmx_kind_type k, input logic [15:0] ad, input logic [7:0] e);
		xfer(k, OP_READ, ad, 8'h00);
		check(q, e);
	endtask

	task automatic clr(input int n);
		repeat (n) @(posedge clock);
		rd_lo = 0;
		wr_lo = 0;
		ale_hi = 0;
		oe_hi = 0;
	endtask

	initial begin
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		rdc(K_DIRECT, 16'h008E, 8'h00);
		rdc(K_DIRECT, 16'h008F, 8'h14);
		rdc(K_DIRECT, 16'h00A2, 8'h00);
		for (int i = 0; i < 8; i++) begin
			rnd = lfsr(rnd);
			a = {9'h000, rnd[6:0]};
			rnd = lfsr(rnd);
			wrt(K_DIRECT, a, rnd);
			rdc(K_INDIRECT, a, rnd);
		end
		for (int b = 0; b < 4; b++) begin
			wrt(K_DIRECT, 16'h008E, 8'(b * 8));
			wrt(K_BANKREG, 16'h0005, 8'hA0 + 8'(b));
			rdc(K_INDIRECT, 16'(b * 8 + 5), 8'hA0 + 8'(b));
		end
		wrt(K_DIRECT, 16'h0021, 8'h00);
		wrt(K_BIT, 16'h000B, 8'h01);
		rdc(K_DIRECT, 16'h0021, 8'h08);
		wrt(K_DIRECT, 16'h002F, 8'h00);
		wrt(K_BIT, 16'h007F, 8'h01);
		rdc(K_DIRECT, 16'h002F, 8'h80);
		wrt(K_INDIRECT, 16'h0090, 8'h5C);
		rdc(K_INDIRECT, 16'h0090, 8'h5C);
		rdc(K_DIRECT, 16'h0090, 8'h00);
		alu <= '{1'b1, 1'b1, 1'b0, 1'b1};
		acc <= 8'h07;
		@(posedge clock);
		alu <= '0;
		@(posedge clock);
		rdc(K_DIRECT, 16'h008E, 8'h9D);
		wrt(K_DIRECT, 16'h008E, 8'h22);
		rdc(K_DIRECT, 16'h008E, 8'h23);
		xfer(K_DATA_POINTER_REG, OP_WRITE, 16'h1111, 8'h00);
		xfer(K_DIRECT, OP_INC, 16'h00A2, 8'h00);
		rdc(K_DIRECT, 16'h00A2, 8'h01);
		xfer(K_DATA_POINTER_REG, OP_WRITE, 16'h2222, 8'h00);
		rdc(K_DIRECT, 16'h0083, 8'h22);
		xfer(K_DIRECT, OP_INC, 16'h00A2, 8'h00);
		rdc(K_DIRECT, 16'h0084, 8'h11);
		xfer(K_DATA_POINTER_REG, OP_INC, 16'h0000, 8'h00);
		rdc(K_DIRECT, 16'h0084, 8'h12);
		xfer(K_DATA_POINTER_REG, OP_WRITE, 16'h07FF, 8'h00);
		wrt(K_MOVX_DP, 16'h0000, 8'h6D);
		rdc(K_MOVX_DP, 16'h0000, 8'h6D);
		check(lat, 16'h0001);
		wrt(K_DIRECT, 16'h00A0, 8'h00);
		wrt(K_MOVX_RI, 16'h0045, 8'h4B);
		rdc(K_MOVX_RI, 16'h0045, 8'h4B);
		check(lat, 16'h0001);
		// size codes 0 to 5: last byte inside, first byte outside
		for (int c = 0; c < 6; c++) begin
			wrt(K_DIRECT, 16'h008F, 8'(c * 4));
			xfer(K_DATA_POINTER_REG, OP_WRITE, SZ_TAB[c] - 16'h0001, 8'h00);
			xfer(K_MOVX_DP, OP_READ, 16'h0000, 8'h00);
			check(lat, 16'h0001);
			xfer(K_DATA_POINTER_REG, OP_WRITE, SZ_TAB[c], 8'h00);
			xfer(K_MOVX_DP, OP_READ, 16'h0000, 8'h00);
			check(lat, 16'h0007);
		end
		clr(3);
		repeat (30) @(posedge clock);
		check(16'(ale_hi), 16'h000A);
		wrt(K_DIRECT, 16'h008F, 8'h15);
		clr(3);
		repeat (30) @(posedge clock);
		check(16'(ale_hi), 16'h0000);
		code_read_strobe <= 1'b1;
		@(posedge clock);
		code_read_strobe <= 1'b0;
		repeat (4) @(posedge clock);
		check(16'(ale_hi), 16'h0001);
		wrt(K_DIRECT, 16'h008F, 8'h17);
		xfer(K_DATA_POINTER_REG, OP_WRITE, 16'h1234, 8'h00);
		rnd = lfsr(rnd);
		clr(1);
		wrt(K_MOVX_DP, 16'h0000, rnd);
		check(lat, 16'h0007);
		check(16'(wr_lo), 16'h0003);
		check(16'(ale_hi), 16'h0001);
		check(p2_seen, 8'h12);
		check(i_dmx_xmem_model.mem[16'h1234], rnd);
		check(16'(oe_hi), 16'h0006);
		check(q, 8'h00);
		clr(1);
		rdc(K_MOVX_DP, 16'h0000, rnd);
		check(16'(rd_lo), 16'h0003);
		check(16'(oe_hi), 16'h0002);
		wrt(K_DIRECT, 16'h00A0, 8'h5A);
		wrt(K_MOVX_RI, 16'h0033, 8'hC6);
		check(p2_seen, 8'h5A);
		check(i_dmx_xmem_model.mem[16'h5A33], 8'hC6);
		wrt(K_DIRECT, 16'h008F, 8'h37);
		slow <= 1'b1;
		rnd = lfsr(rnd);
		clr(1);
		wrt(K_MOVX_DP, 16'h0000, rnd);
		check(lat, 16'h0013);
		check(16'(wr_lo), 16'h000F);
		clr(1);
		rdc(K_MOVX_DP, 16'h0000, rnd);
		check(lat, 16'h0013);
		check(16'(rd_lo), 16'h000F);
		stop_test();
	end
endmodule // dmx_data_mem_bench

// File: dmx_pkg.sv
/*
 Constants, types and shared helpers for the data-memory decoder and external bus sequencer.
 Assumes one CPU clock, on which every request and every ALU flag update arrives.
*/
package dmx_pkg;
	localparam logic [7:0] BIT_BASE = 8'h20;
	localparam logic [7:0] SFR_DPH = 8'h83;
	localparam logic [7:0] SFR_DPL = 8'h84;
	localparam logic [7:0] SFR_PSW = 8'h8E;
	localparam logic [7:0] SFR_AUX = 8'h8F;
	localparam logic [7:0] SFR_P2 = 8'hA0;
	localparam logic [7:0] SFR_AUX1 = 8'hA2;
	localparam logic [7:0] PSW_RST = 8'h00;
	localparam logic [5:0] AUX_RST = 6'h14;
	localparam logic [7:0] AUX1_RST = 8'h00;
	localparam logic [7:0] AUX1_MASK = 8'h29;
	localparam logic [7:0] P2_RST = 8'hFF;
	localparam int PSW_CY = 7;
	localparam int PSW_AC = 6;
	localparam int PSW_OV = 2;
	localparam int PSW_RS_HI = 4;
	localparam int PSW_RS_LO = 3;
	localparam int AUX_STRETCH = 5;
	localparam int AUX_SZ_HI = 4;
	localparam int AUX_SZ_LO = 2;
	localparam int AUX_EXT = 1;
	localparam int AUX_SUPP = 0;
	localparam int AUX1_PSEL = 0;
	localparam int EXPANDED_RAM_DEPTH = 2048;
	localparam logic [3:0] ALE_CLKS = 4'h2;
	localparam logic [3:0] STROBE_STD = 4'h3;
	localparam logic [3:0] STROBE_STRETCH = 4'hF;
	localparam logic [1:0] ALE_DIV_LAST = 2'h2;

	typedef enum logic [2:0] {
		K_DIRECT = 3'h0, K_INDIRECT = 3'h1, K_BANKREG = 3'h2, K_BIT = 3'h3,
		K_MOVX_RI = 3'h4, K_MOVX_DP = 3'h5, K_DATA_POINTER_REG = 3'h6
	} dmx_kind_type;
	typedef enum logic [1:0] {OP_READ = 2'h0, OP_WRITE = 2'h1, OP_INC = 2'h2} dmx_op_type;
	typedef enum logic [2:0] {
		T_NONE = 3'h0, T_IRAM = 3'h1, T_SFR = 3'h2, T_EXPANDED_RAM = 3'h3, T_XBUS = 3'h4, T_DATA_POINTER_REG = 3'h5
	} dmx_tgt_type;
	typedef enum logic [1:0] {S_IDLE = 2'h0, S_ADDR = 2'h1, S_STRB = 2'h3, S_HOLD = 2'h2} dmx_state_type;

	typedef struct packed {
		logic valid;
		dmx_kind_type kind;
		dmx_op_type op;
		logic [15:0] addr;
		logic [7:0] wdata;
	} dmx_req_type;
	typedef struct packed {
		logic valid;
		logic [7:0] rdata;
	} dmx_rsp_type;
	typedef struct packed {
		logic valid;
		logic carry;
		logic half;
		logic ovf;
	} dmx_alu_type;
	typedef struct packed {
		logic ale;
		logic rd_n;
		logic wr_n;
		logic [7:0] p0_out;
		logic p0_oe;
		logic [7:0] p2_out;
	} dmx_bus_type;

	// reserved codes behave as full size
	function automatic logic [11:0] expanded_ram_size_bytes(input logic [2:0] code);
		unique case (code)
			3'h0: return 12'h100;
			3'h1: return 12'h200;
			3'h2: return 12'h300;
			3'h3: return 12'h400;
			3'h4: return 12'h700;
			default: return 12'h800;
		endcase
	endfunction

	function automatic logic [7:0] set_bit(input logic [7:0] b, input logic [2:0] i, input logic v);
		logic [7:0] r;
		r = b;
		r[i] = v;
		return r;
	endfunction
endpackage

// File: dmx_xbus_seq.sv
/*
 External data bus sequencer: address, strobe and hold phases, latch strobe divider.
 Assumes start only while busy is low; port zero input arrives from a pin.
*/
`timescale 1ns/1ps
module dmx_xbus_seq import dmx_pkg::*; (
	input wire logic clock,
	input wire logic rst,
	input wire logic start,
	input wire logic wr,
	input wire logic [15:0] addr,
	input wire logic [7:0] wdata,
	input wire logic stretch,
	input wire logic suppress,
	input wire logic code_read_strobe,
	input wire logic [7:0] p0_in,
	output logic busy,
	output logic done,
	output logic [7:0] rdata,
	output dmx_bus_type bus
);
	dmx_state_type st_r, st_nxt;
	logic [3:0] cnt_r, cnt_nxt, width_r;
	logic wr_r;
	logic [7:0] wdata_r, p0_s1_r, p0_s2_r;
	logic [1:0] div_r;

	assign busy = st_r != S_IDLE;
	assign done = st_r == S_HOLD;
	assign rdata = p0_s2_r;

	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r + 4'h1;
		unique case (st_r)
			S_IDLE: begin
				cnt_nxt = 4'h0;
				if (start)
					st_nxt = S_ADDR;
			end
			S_ADDR: if (cnt_r == ALE_CLKS - 4'h1) begin
				st_nxt = S_STRB;
				cnt_nxt = 4'h0;
			end
			S_STRB: if (cnt_r == width_r - 4'h1) begin
				st_nxt = S_HOLD;
				cnt_nxt = 4'h0;
			end
			S_HOLD: st_nxt = S_IDLE;
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			st_r <= S_IDLE;
			cnt_r <= 4'h0;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			wr_r <= 1'b0;
			wdata_r <= 8'h00;
			width_r <= STROBE_STD;
		end else if (start && !busy) begin
			wr_r <= wr;
			wdata_r <= wdata;
			width_r <= stretch ? STROBE_STRETCH : STROBE_STD;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			p0_s1_r <= 8'h00;
			p0_s2_r <= 8'h00;
		end else begin
			p0_s1_r <= p0_in;
			p0_s2_r <= p0_s1_r;
		end
	end

	always_ff @(posedge clock) begin
		if (rst)
			div_r <= 2'h0;
		else
			div_r <= (div_r == ALE_DIV_LAST) ? 2'h0 : div_r + 2'h1;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			bus <= '{ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1, p0_out: 8'h00, p0_oe: 1'b0, p2_out: 8'h00};
		end else begin
			bus.ale <= (st_nxt == S_ADDR && cnt_nxt == 4'h0) ||
				(st_nxt == S_IDLE && (code_read_strobe || (!suppress && div_r == ALE_DIV_LAST)));
			bus.rd_n <= !(st_nxt == S_STRB && !wr_r);
			bus.wr_n <= !(st_nxt == S_STRB && wr_r);
			bus.p0_oe <= st_nxt == S_ADDR || (wr_r && st_nxt != S_IDLE);
			if (start && !busy) begin
				bus.p0_out <= addr[7:0];
				bus.p2_out <= addr[15:8];
			end else if (st_r == S_ADDR && st_nxt == S_STRB) begin
				bus.p0_out <= wdata_r;
			end
		end
	end
endmodule // dmx_xbus_seq

// File: dmx_xmem_model.sv
/*
 External data memory on the multiplexed bus: latches the address, stores and returns bytes.
 Assumes the bus struct of the decoder; slow delays read data by six strobe clocks.
*/
`timescale 1ns/1ps
module dmx_xmem_model import dmx_pkg::*; (
	input wire logic clock,
	input wire logic slow,
	input dmx_bus_type bus,
	output logic [7:0] p0_in
);
	logic [7:0] mem [0:65535];
	logic [15:0] addr_r;
	logic [7:0] last_r = 8'h00;
	logic [3:0] wait_r = 4'h0;
	always @(posedge clock) begin
		// address taken only while the latch strobe is high
		if (bus.ale) addr_r <= {bus.p2_out, bus.p0_out};
		if (!bus.wr_n) mem[addr_r] <= bus.p0_out;
		wait_r <= bus.rd_n ? 4'h0 : ((wait_r == 4'hF) ? wait_r : wait_r + 4'h1);
		last_r <= p0_in;
	end
	// released pins flip every cycle rather than hold the old byte
	assign p0_in = (!bus.rd_n && (!slow || wait_r >= 4'h6)) ? mem[addr_r] : ~last_r;
endmodule // dmx_xmem_model
